// *** hw/spsv_pkg.sv ***
// Shared constants and helpers of the serial port select and verify block
`default_nettype none

package spsv_pkg;

  // Register locations in the device address space
  localparam logic [15:0] ADDR_VALUE_32 = 16'hE5FF;  // Trace data, 32-bit view
  localparam logic [15:0] ADDR_REVISION = 16'hE707;  // Die revision
  localparam logic [15:0] ADDR_VALUE_8 = 16'hE7FD;   // Trace data, 8-bit view
  localparam logic [15:0] ADDR_LOCATION = 16'hE9FE;  // Trace address
  localparam logic [15:0] ADDR_VALUE_16 = 16'hE9FF;  // Trace data, 16-bit view
  localparam logic [15:0] ADDR_SECONDARY_CONFIG = 16'hEA00;   // Secondary config
  localparam logic [15:0] ADDR_KIND = 16'hEA01;      // Trace operation kind

  // Operation kind codes
  localparam logic [7:0] KIND_WRITE = 8'hCA;  // Last access was a write
  localparam logic [7:0] KIND_READ = 8'h35;   // Last access was a read

  // Reset values
  localparam logic [7:0] KIND_RESET = 8'h00;
  localparam logic [15:0] LOC_RESET = 16'h0000;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // Field positions
  localparam int CFG2_I2C_LOCK_BIT = 0;  // Locks the two-wire port

  // Access size codes
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  // Port identifiers on the access strobes
  localparam logic PORT_I2C = 1'b0;
  localparam logic PORT_SPI = 1'b1;

  // Port selection and capture figures
  localparam logic [1:0] SEL_FALLS_MINUS1 = 2'h2;  // Third fall selects SPI
  localparam logic [1:0] SEL_COUNT_RESET = 2'h0;
  localparam int CAPTURE_REGS_MAX = 16;            // Capture register slots

  // Port mode of the selector
  typedef enum logic {SPSV_MODE_I2C, SPSV_MODE_SPI} spsv_mode_t;

  // One of the three trace registers or their data views
  function automatic logic is_trace_addr(input logic [15:0] addr);
    is_trace_addr = (addr == ADDR_VALUE_8) || (addr == ADDR_VALUE_16) ||
                    (addr == ADDR_VALUE_32) || (addr == ADDR_LOCATION) ||
                    (addr == ADDR_KIND);
  endfunction : is_trace_addr

  // Address served by this block
  function automatic logic is_local_addr(input logic [15:0] addr);
    is_local_addr = is_trace_addr(addr) || (addr == ADDR_REVISION) ||
                    (addr == ADDR_SECONDARY_CONFIG);
  endfunction : is_local_addr

  // Keeps only the bytes that an access of this size moved
  function automatic logic [31:0] size_mask(input logic [1:0] size,
                                            input logic [31:0] data);
    unique case (size)
      SIZE_8: size_mask = {24'h00_0000, data[7:0]};
      SIZE_16: size_mask = {16'h0000, data[15:0]};
      default: size_mask = data;
    endcase
  endfunction : size_mask

endpackage : spsv_pkg

`default_nettype wire

// *** hw/spsv_sel_detect.sv ***
// Chip-select fall counter that picks and locks the serial port
`default_nettype none

module spsv_sel_detect (
  input wire logic clk,         // Device clock
  input wire logic rst_b,       // Async reset, active low
  input wire logic clear,       // Power-down clear
  input wire logic sel_pin_b,   // Shared chip-select pin level
  input wire logic lock_set,    // Lock request from config write
  output logic spi_active_ff,   // SPI port selected
  output logic locked_ff        // Port choice locked
);

  // All selector state in one word
  typedef struct packed {
    logic prev_pin;                // Pin level one clock ago
    logic [1:0] falls;             // Falls seen so far
    spsv_pkg::spsv_mode_t mode;    // Active port
    logic locked;                  // Choice frozen
  } spsv_sel_t;

  localparam spsv_sel_t SEL_RESET = '{
    prev_pin: 1'b1,
    falls: spsv_pkg::SEL_COUNT_RESET,
    mode: spsv_pkg::SPSV_MODE_I2C,
    locked: 1'b0
  };

  spsv_sel_t sel_ff;
  spsv_sel_t nxt_sel;
  logic pin_fall;  // High to low step on the pin

  assign pin_fall = sel_ff.prev_pin & ~sel_pin_b;

  // Next state: count falls while unlocked in two-wire mode
  always_comb begin
    nxt_sel = sel_ff;
    nxt_sel.prev_pin = sel_pin_b;
    if (clear) begin
      // Power-down drops the choice like a hardware reset
      nxt_sel = SEL_RESET;
    end else begin
      unique case (sel_ff.mode)
        spsv_pkg::SPSV_MODE_I2C: begin
          // Locked two-wire mode ignores stray toggles
          if (pin_fall && !sel_ff.locked) begin
            if (sel_ff.falls == spsv_pkg::SEL_FALLS_MINUS1) begin
              nxt_sel.mode = spsv_pkg::SPSV_MODE_SPI;
            end else begin
              nxt_sel.falls = sel_ff.falls + 2'h1;
            end
          end
        end
        spsv_pkg::SPSV_MODE_SPI: begin
          // SPI has no way back short of reset or power-down
          nxt_sel.mode = spsv_pkg::SPSV_MODE_SPI;
        end
      endcase
      if (lock_set) begin
        nxt_sel.locked = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_ff <= SEL_RESET;
    end else begin
      sel_ff <= nxt_sel;
    end
  end

  assign spi_active_ff = (sel_ff.mode == spsv_pkg::SPSV_MODE_SPI);
  assign locked_ff = sel_ff.locked;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_THIRD_FALL_SPI: assert property (
    (sel_ff.falls == spsv_pkg::SEL_FALLS_MINUS1) && pin_fall &&
    !sel_ff.locked && !clear |=> spi_active_ff)
    else $error("third fall did not select SPI");

  AST_HIGH_KEEPS_I2C: assert property (
    !spi_active_ff && !pin_fall && !clear |=> !spi_active_ff)
    else $error("two-wire mode left without a fall");

  AST_I2C_LOCK_HOLDS: assert property (
    (locked_ff && !spi_active_ff && !clear) |=> !spi_active_ff)
    else $error("locked two-wire mode switched to SPI");

  COV_SPI_SELECTED: cover property (!spi_active_ff ##1 spi_active_ff);

endmodule : spsv_sel_detect

`default_nettype wire

// *** hw/spsv_core.sv ***
// Serial port selection, locking and access trace registers
`default_nettype none

module spsv_core #(
  parameter int CAPTURE_MAX = spsv_pkg::CAPTURE_REGS_MAX,  // Capture slots
  parameter logic [7:0] DIE_REVISION = 8'h01  // Arbitrary value
) (
  input wire logic clk,                  // Device clock, 40 MHz
  input wire logic rst_b,                // Async hardware reset, low
  input wire logic power_down,           // Power-down, clears like reset
  input wire logic sel_pin_b,            // Shared chip-select pin
  input wire logic req,                  // Register read request pulse
  input wire logic req_port,             // Port that carries the request
  input wire logic [15:0] req_addr,      // Register to read
  input wire logic done,                 // Access finished pulse
  input wire logic done_ok,              // All bytes moved, no error
  input wire logic done_port,            // Port that carried the access
  input wire logic done_write,           // Access was a write
  input wire logic [15:0] done_addr,     // Register accessed
  input wire logic [1:0] done_size,      // Register width code
  input wire logic [31:0] done_data,     // Data written or read
  input wire logic capture_enable,       // Software enable of capture
  input wire logic [4:0] capture_regs,   // Capture registers asked
  output logic rsp_valid_ff,             // Read answer pulse
  output logic rsp_hit_ff,               // Address served here
  output logic [31:0] rsp_data_ff,       // Read answer data
  output logic spi_active_ff,            // SPI port in use
  output logic port_locked_ff,           // Port choice locked
  output logic capture_on_ff,            // Capture port running
  output logic [4:0] capture_count_ff,   // Registers it delivers
  output logic [7:0] secondary_config_ff          // Secondary config value
);

  // Capture slot limit at the counter width
  localparam logic [4:0] CAP_LIMIT = 5'(CAPTURE_MAX);

  // All core state in one word
  typedef struct packed {
    logic [7:0] cfg2;       // Secondary config contents
    logic [7:0] kind;       // Kind of last good access
    logic [15:0] loc;       // Address of last good access
    logic [31:0] value;     // Data of last good access
    logic rsp_valid;        // Read answer strobe
    logic rsp_hit;          // Read answer came from here
    logic [31:0] rsp_data;  // Read answer data
    logic cap_on;           // Capture port running
    logic [4:0] cap_count;  // Capture slot count
  } spsv_core_t;

  localparam spsv_core_t CORE_RESET = '{
    cfg2: spsv_pkg::CFG2_RESET,
    kind: spsv_pkg::KIND_RESET,
    loc: spsv_pkg::LOC_RESET,
    value: spsv_pkg::VALUE_RESET,
    rsp_valid: 1'b0,
    rsp_hit: 1'b0,
    rsp_data: spsv_pkg::DATA_ZERO,
    cap_on: 1'b0,
    cap_count: 5'h00
  };

  spsv_core_t core_ff;
  spsv_core_t nxt_core;
  logic active_port;   // Port identifier now in charge
  logic accepted;      // Finished access counts as good
  logic trace_read;    // Good read of a trace register
  logic cfg2_write;    // Good write to secondary config
  logic lock_set;      // Freeze the port choice now
  logic sel_locked;    // Selector lock flag

  // Read data of every register served here
  function automatic logic [31:0] read_value(input logic [15:0] addr,
                                             input spsv_core_t st);
    unique case (addr)
      spsv_pkg::ADDR_VALUE_8: read_value = {24'h00_0000, st.value[7:0]};
      spsv_pkg::ADDR_VALUE_16: read_value = {16'h0000, st.value[15:0]};
      spsv_pkg::ADDR_VALUE_32: read_value = st.value;
      spsv_pkg::ADDR_LOCATION: read_value = {16'h0000, st.loc};
      spsv_pkg::ADDR_KIND: read_value = {24'h00_0000, st.kind};
      spsv_pkg::ADDR_SECONDARY_CONFIG: read_value = {24'h00_0000, st.cfg2};
      spsv_pkg::ADDR_REVISION: read_value = {24'h00_0000, DIE_REVISION};
      // Foreign addresses answer zero and drop the hit flag
      default: read_value = spsv_pkg::DATA_ZERO;
    endcase
  endfunction : read_value

  // Port picker; its lock is fed by config writes below
  spsv_sel_detect u_sel (
    .clk(clk),
    .rst_b(rst_b),
    .clear(power_down),
    .sel_pin_b(sel_pin_b),
    .lock_set(lock_set),
    .spi_active_ff(spi_active_ff),
    .locked_ff(sel_locked)
  );

  assign port_locked_ff = sel_locked;

  // Only traffic from the selected port reaches the registers
  assign active_port = spi_active_ff ? spsv_pkg::PORT_SPI :
                                       spsv_pkg::PORT_I2C;

  // Engines flag ok only for complete, error-free frames
  assign accepted = done && done_ok && (done_port == active_port);

  // Reading the trace must not overwrite it with itself
  assign trace_read = accepted && !done_write &&
                      spsv_pkg::is_trace_addr(done_addr);

  assign cfg2_write = accepted && done_write &&
                      (done_addr == spsv_pkg::ADDR_SECONDARY_CONFIG);

  // Two-wire locks only on the bit; SPI locks on any write
  assign lock_set = cfg2_write && (spi_active_ff ||
                    done_data[spsv_pkg::CFG2_I2C_LOCK_BIT]);

  // Next state of registers, answers and capture control
  always_comb begin
    nxt_core = core_ff;
    nxt_core.rsp_valid = 1'b0;
    // Read answer one clock after the request
    if (req && (req_port == active_port)) begin
      nxt_core.rsp_valid = 1'b1;
      nxt_core.rsp_hit = spsv_pkg::is_local_addr(req_addr);
      nxt_core.rsp_data = read_value(req_addr, core_ff);
    end
    // Config write lands only when the frame completed cleanly
    if (cfg2_write) begin
      nxt_core.cfg2 = done_data[7:0];
    end
    // Trace update; failed frames never get here
    if (accepted && !trace_read) begin
      nxt_core.kind = done_write ? spsv_pkg::KIND_WRITE :
                                   spsv_pkg::KIND_READ;
      nxt_core.loc = done_addr;
      nxt_core.value = spsv_pkg::size_mask(done_size, done_data);
    end
    // Capture shares pins with SPI, so SPI keeps it off
    nxt_core.cap_on = capture_enable && !spi_active_ff;
    // Requests above the slot limit are clipped to it
    nxt_core.cap_count = (capture_regs > CAP_LIMIT) ? CAP_LIMIT :
                                                     capture_regs;
    if (power_down) begin
      // Power-down clears everything, lock included
      nxt_core = CORE_RESET;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ff <= CORE_RESET;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // Outputs come straight from the state word
  assign rsp_valid_ff = core_ff.rsp_valid;
  assign rsp_hit_ff = core_ff.rsp_hit;
  assign rsp_data_ff = core_ff.rsp_data;
  assign capture_on_ff = core_ff.cap_on;
  assign capture_count_ff = core_ff.cap_count;
  assign secondary_config_ff = core_ff.cfg2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_CAPTURE_NEEDS_ENABLE: assert property (
    !capture_enable |=> !capture_on_ff)
    else $error("capture running without enable");

  AST_NO_CAPTURE_UNDER_SPI: assert property (
    spi_active_ff ##1 spi_active_ff |-> !capture_on_ff)
    else $error("capture running while SPI active");

  AST_SPI_CONFIG_LOCKS: assert property (
    cfg2_write && spi_active_ff && !power_down |=> port_locked_ff)
    else $error("config write under SPI did not lock");

  AST_LOCK_STAYS: assert property (
    port_locked_ff && !power_down |=> port_locked_ff)
    else $error("lock lost without reset or power-down");

  AST_READ_ANSWERED: assert property (
    req && (req_port == active_port) && !power_down |=> rsp_valid_ff)
    else $error("read on active port not answered");

  AST_FOREIGN_IGNORED: assert property (
    req && (req_port != active_port) |=> !rsp_valid_ff)
    else $error("read on idle port answered");

  AST_KIND_CODE: assert property (
    accepted && !trace_read && !power_down |=>
    core_ff.kind == ($past(done_write) ? spsv_pkg::KIND_WRITE :
                                         spsv_pkg::KIND_READ))
    else $error("kind register wrong after access");

  AST_LOC_RECORDED: assert property (
    accepted && !trace_read && !power_down |=>
    core_ff.loc == $past(done_addr))
    else $error("address trace not recorded");

  AST_FAIL_NO_TRACE: assert property (
    (!accepted || trace_read) && !power_down |=>
    $stable(core_ff.kind) && $stable(core_ff.loc) &&
    $stable(core_ff.value))
    else $error("trace changed without a good access");

  AST_VALUE16_VIEW: assert property (
    req && (req_port == active_port) && !power_down &&
    (req_addr == spsv_pkg::ADDR_VALUE_16) |=>
    rsp_data_ff == {16'h0000, $past(core_ff.value[15:0])})
    else $error("16-bit trace view wrong");

  AST_REVISION_READ: assert property (
    req && (req_port == active_port) && !power_down &&
    (req_addr == spsv_pkg::ADDR_REVISION) |=>
    rsp_data_ff == {24'h00_0000, DIE_REVISION} && rsp_hit_ff)
    else $error("die revision read wrong");

  AST_CAPTURE_CLIPPED: assert property (
    ##1 capture_count_ff <= CAP_LIMIT)
    else $error("capture count above slot limit");

  // Trace views answer with the stored word, upper bits zero except in the 32-bit view
  AST_VALUE8_VIEW: assert property (
    req && (req_port == active_port) && !power_down &&
    (req_addr == spsv_pkg::ADDR_VALUE_8) |=>
    rsp_data_ff == {24'h00_0000, $past(core_ff.value[7:0])})
    else $error("8-bit trace view wrong");

  AST_VALUE32_VIEW: assert property (
    req && (req_port == active_port) && !power_down &&
    (req_addr == spsv_pkg::ADDR_VALUE_32) |=>
    rsp_data_ff == $past(core_ff.value))
    else $error("32-bit trace view wrong");

  AST_LOC_VIEW: assert property (
    req && (req_port == active_port) && !power_down &&
    (req_addr == spsv_pkg::ADDR_LOCATION) |=>
    rsp_data_ff == {16'h0000, $past(core_ff.loc)})
    else $error("address trace view wrong");

  // A trace read-back must not store its own data
  AST_TRACE_READ_KEEPS: assert property (
    trace_read && !power_down |=> $stable(core_ff.value))
    else $error("trace read overwrote stored data");

  // Two-wire lock needs the bit; without it the port stays free
  AST_I2C_LOCK_BIT: assert property (
    cfg2_write && !spi_active_ff && !power_down &&
    done_data[spsv_pkg::CFG2_I2C_LOCK_BIT] |=> port_locked_ff)
    else $error("two-wire lock bit did not lock");

  AST_I2C_NO_BIT_FREE: assert property (
    !port_locked_ff && !spi_active_ff &&
    !(cfg2_write && done_data[spsv_pkg::CFG2_I2C_LOCK_BIT]) |=>
    !port_locked_ff)
    else $error("two-wire port locked without the bit");

  AST_CONFIG_STORED: assert property (
    cfg2_write && !power_down |=> secondary_config_ff == $past(done_data[7:0]))
    else $error("config write not stored");

  // Traffic on the idle port must leave the config alone
  AST_IDLE_PORT_NO_WRITE: assert property (
    done && (done_port != active_port) && !power_down |=>
    $stable(secondary_config_ff))
    else $error("idle port changed the config");

  // Power-down behaves like a hardware reset for the choice
  AST_POWER_DOWN_CLEARS: assert property (
    power_down |=> !port_locked_ff && !spi_active_ff && !capture_on_ff)
    else $error("power-down left state behind");

  AST_CAPTURE_FOLLOWS: assert property (
    capture_enable && !spi_active_ff && !power_down |=> capture_on_ff)
    else $error("capture enable ignored in two-wire mode");

  COV_I2C_LOCKED: cover property (lock_set && !spi_active_ff);
  COV_SPI_LOCKED: cover property (lock_set && spi_active_ff);
  COV_WRITE_TRACED: cover property (accepted && done_write && !trace_read);
  COV_FAIL_DROPPED: cover property (done && !done_ok);

endmodule : spsv_core

`default_nettype wire

// *** dv/spsv_host_model.sv ***
// Host master model: drives the shared select pin and the access strobes
`default_nettype none

module spsv_host_model (
  input wire logic clk,                // Device clock
  input wire logic rsp_valid_ff,       // Read answer pulse
  input wire logic rsp_hit_ff,         // Address served by the block
  input wire logic [31:0] rsp_data_ff, // Read answer data
  output var logic sel_pin_b,          // Shared chip-select pin
  output var logic req,                // Read request pulse
  output var logic req_port,           // Port of the request
  output var logic [15:0] req_addr,    // Register to read
  output var logic done,               // Access finished pulse
  output var logic done_ok,            // Access moved every byte
  output var logic done_port,          // Port of the access
  output var logic done_write,         // Write when high
  output var logic [15:0] done_addr,   // Register accessed
  output var logic [1:0] done_size,    // Width code
  output var logic [31:0] done_data    // Data moved
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle state: pin pulled high, strobes low
  initial begin
    sel_pin_b = 1'b1;
    {req, req_port, done, done_ok, done_port, done_write} = 6'h00;
    req_addr = 16'h0000;
    done_addr = 16'h0000;
    done_size = 2'h0;
    done_data = 32'h0000_0000;
  end

  // Pin used as a plain output, n falls each two cycles long
  task automatic toggle_sel(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #2 sel_pin_b = 1'b0;
      repeat (2) @(posedge clk);
      #2 sel_pin_b = 1'b1;
    end
  endtask : toggle_sel

  // One finished access; ok low marks a broken transfer
  task automatic access(input logic port, input logic wr, input logic ok,
                        input logic [15:0] addr, input logic [1:0] size,
                        input logic [31:0] data);
    @(posedge clk);
    #2 {done, done_ok, done_port, done_write} = {1'b1, ok, port, wr};
    done_addr = addr;
    done_size = size;
    done_data = data;
    @(posedge clk);
    // Released bus shows the inverse, so stale values never match
    #2 done = 1'b0;
    done_addr = ~addr;
    done_data = ~data;
  endtask : access

  // Read request; the answer is sampled just after the edge that takes it
  task automatic read(input logic port, input logic [15:0] addr,
                      output logic v, output logic h, output logic [31:0] d);
    @(posedge clk);
    #2 {req, req_port} = {1'b1, port};
    req_addr = addr;
    @(posedge clk);
    #1 v = rsp_valid_ff;
    h = rsp_hit_ff;
    d = rsp_data_ff;
    #1 req = 1'b0;
    req_addr = ~addr;
  endtask : read
endmodule : spsv_host_model

`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench of the port select and access trace block
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'h5A; // Arbitrary revision value
  logic clk = 1'b0;
  logic rst_b, power_down, capture_enable; // Bench driven controls
  logic [4:0] capture_regs; // Capture slots asked
  logic sel_pin_b, req, req_port, done, done_ok, done_port, done_write;
  logic [15:0] req_addr, done_addr;
  logic [1:0] done_size;
  logic [31:0] done_data, rsp_data_ff;
  logic rsp_valid_ff, rsp_hit_ff, spi_active_ff, port_locked_ff;
  logic capture_on_ff;
  logic [4:0] capture_count_ff;
  logic [7:0] secondary_config_ff;
  logic v, h; // Last read answer
  logic [31:0] d;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  // 40 MHz device clock
  always #12.5 clk = ~clk;

  spsv_core #(.CAPTURE_MAX(16), .DIE_REVISION(REV)) spsv_core_inst (
    .clk(clk), .rst_b(rst_b), .power_down(power_down),
    .sel_pin_b(sel_pin_b), .req(req), .req_port(req_port),
    .req_addr(req_addr), .done(done), .done_ok(done_ok),
    .done_port(done_port), .done_write(done_write), .done_addr(done_addr),
    .done_size(done_size), .done_data(done_data),
    .capture_enable(capture_enable), .capture_regs(capture_regs),
    .rsp_valid_ff(rsp_valid_ff), .rsp_hit_ff(rsp_hit_ff),
    .rsp_data_ff(rsp_data_ff), .spi_active_ff(spi_active_ff),
    .port_locked_ff(port_locked_ff), .capture_on_ff(capture_on_ff),
    .capture_count_ff(capture_count_ff), .secondary_config_ff(secondary_config_ff));

  spsv_host_model spsv_host_model_inst (
    .clk(clk), .rsp_valid_ff(rsp_valid_ff), .rsp_hit_ff(rsp_hit_ff),
    .rsp_data_ff(rsp_data_ff), .sel_pin_b(sel_pin_b), .req(req),
    .req_port(req_port), .req_addr(req_addr), .done(done),
    .done_ok(done_ok), .done_port(done_port), .done_write(done_write),
    .done_addr(done_addr), .done_size(done_size), .done_data(done_data));

  // Compare one value, report and count a mismatch
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Counts, verdict and end of run
  task automatic end_of_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // Waits n edges then settles past them
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  // Reads one register over the two-wire port
  task automatic rd(input logic [15:0] a);
    spsv_host_model_inst.read(spsv_pkg::PORT_I2C, a, v, h, d);
  endtask : rd

  // Reset state and the capture port gate
  task automatic t_capture();
    check({spi_active_ff, port_locked_ff, capture_on_ff}, 3'h0);
    capture_regs = 5'h14;
    capture_enable = 1'b1;
    wait_cyc(2);
    check(capture_on_ff, 1'b1);
    check(capture_count_ff, 5'h10);
    #1 capture_regs = 5'h03;
    wait_cyc(2);
    check(capture_count_ff, 5'h03);
  endtask : t_capture

  // Trace registers over the two-wire port
  task automatic t_trace();
    spsv_host_model_inst.access(1'b0, 1'b1, 1'b1, 16'h1234,
                                spsv_pkg::SIZE_16, 32'hABCD_5678);
    rd(spsv_pkg::ADDR_LOCATION);
    check({v, h, d}, {2'h3, 32'h0000_1234});
    rd(spsv_pkg::ADDR_KIND);
    check(d, 32'h0000_00CA);
    rd(spsv_pkg::ADDR_VALUE_16);
    check(d, 32'h0000_5678);
    // Reading a trace back, a failed write and a wrong-port write
    spsv_host_model_inst.access(1'b0, 1'b0, 1'b1, spsv_pkg::ADDR_KIND,
                                spsv_pkg::SIZE_8, 32'h0000_00CA);
    spsv_host_model_inst.access(1'b0, 1'b1, 1'b0, 16'h7777,
                                spsv_pkg::SIZE_8, 32'h0000_0011);
    spsv_host_model_inst.access(1'b1, 1'b1, 1'b1, 16'h6666,
                                spsv_pkg::SIZE_8, 32'h0000_0022);
    rd(spsv_pkg::ADDR_LOCATION);
    check(d, 32'h0000_1234);
    rd(spsv_pkg::ADDR_KIND);
    check(d, 32'h0000_00CA);
    spsv_host_model_inst.access(1'b0, 1'b0, 1'b1, 16'h4321,
                                spsv_pkg::SIZE_8, 32'h0000_00A5);
    rd(spsv_pkg::ADDR_KIND);
    check(d, 32'h0000_0035);
    rd(spsv_pkg::ADDR_VALUE_8);
    check(d, 32'h0000_00A5);
    spsv_host_model_inst.access(1'b0, 1'b1, 1'b1, spsv_pkg::ADDR_REVISION,
                                spsv_pkg::SIZE_32, 32'hDEAD_BEEF);
    rd(spsv_pkg::ADDR_VALUE_32);
    check(d, 32'hDEAD_BEEF);
    rd(spsv_pkg::ADDR_REVISION);
    check({v, h, d}, {2'h3, 24'h00_0000, REV});
    rd(16'hEBFF);
    check({v, h, d}, {2'h2, 32'h0000_0000});
    spsv_host_model_inst.read(1'b1, spsv_pkg::ADDR_REVISION, v, h, d);
    check(v, 1'b0);
  endtask : t_trace

  // Two-wire lock needs bit 0 and then ignores the pin
  task automatic t_i2c_lock();
    spsv_host_model_inst.access(1'b0, 1'b1, 1'b1, spsv_pkg::ADDR_SECONDARY_CONFIG,
                                spsv_pkg::SIZE_8, 32'h0000_0000);
    wait_cyc(0);
    check(port_locked_ff, 1'b0);
    spsv_host_model_inst.access(1'b0, 1'b1, 1'b1, spsv_pkg::ADDR_SECONDARY_CONFIG,
                                spsv_pkg::SIZE_8, 32'h0000_0001);
    wait_cyc(0);
    check({port_locked_ff, secondary_config_ff}, 9'h101);
    spsv_host_model_inst.toggle_sel(4);
    wait_cyc(3);
    check({spi_active_ff, port_locked_ff}, 2'h1);
  endtask : t_i2c_lock

  // Hardware reset, three falls select SPI, any config write locks it
  task automatic t_spi();
    @(posedge clk);
    #2 rst_b = 1'b0;
    wait_cyc(1);
    check({port_locked_ff, secondary_config_ff}, 9'h000);
    #1 rst_b = 1'b1;
    spsv_host_model_inst.toggle_sel(3);
    wait_cyc(2);
    check({spi_active_ff, capture_on_ff}, 2'h2);
    spsv_host_model_inst.read(1'b1, spsv_pkg::ADDR_REVISION, v, h, d);
    check({v, d}, {1'b1, 24'h00_0000, REV});
    rd(spsv_pkg::ADDR_REVISION);
    check(v, 1'b0);
    spsv_host_model_inst.access(1'b1, 1'b1, 1'b1, spsv_pkg::ADDR_SECONDARY_CONFIG,
                                spsv_pkg::SIZE_8, 32'h0000_0000);
    wait_cyc(0);
    check({spi_active_ff, port_locked_ff}, 2'h3);
  endtask : t_spi

  // Power-down clears the lock; only the third fall switches
  task automatic t_pdown();
    @(posedge clk);
    #2 power_down = 1'b1;
    @(posedge clk);
    #2 power_down = 1'b0;
    check({spi_active_ff, port_locked_ff}, 2'h0);
    spsv_host_model_inst.toggle_sel(2);
    wait_cyc(3);
    check(spi_active_ff, 1'b0);
    spsv_host_model_inst.toggle_sel(1);
    wait_cyc(2);
    check(spi_active_ff, 1'b1);
  endtask : t_pdown

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    power_down = 1'b0;
    capture_enable = 1'b0;
    capture_regs = 5'h00;
    repeat (5) @(posedge clk);
    #2 rst_b = 1'b1;
    t_capture();
    t_trace();
    t_i2c_lock();
    t_spi();
    t_pdown();
    end_of_test();
  end
endmodule : tb

`default_nettype wire
